// ### verilog/i2sm_consts.svh
// constants of the i2c status and address-mask block
// assumes inclusion by bare name from package and modules
//
// Notes on behaviour
// - status bit 3 set on start or repeated start, cleared on stop.
// - status bit 2 holds direction after slave address: 1 read, 0 write.
// - status bit 1 set on byte into rx holding, cleared by its read.
// - status bit 0 set when software writes the tx holding register.
// - status bit 0 cleared once the transmitted byte has shifted out.
// - mask bit set means that address bit is ignored in matching.
// - mask bits 31 to 10 read zero and ignore writes.
`ifndef I2SM_CONSTS_SVH
`define I2SM_CONSTS_SVH

// register byte offsets
`define I2SM_OFS_STATUS   8'h00
`define I2SM_OFS_MASK     8'h04
`define I2SM_OFS_OWN      8'h08
`define I2SM_OFS_RX       8'h0C
`define I2SM_OFS_TX       8'h10
`define I2SM_OFS_IRQ_ST   8'h14
`define I2SM_OFS_IRQ_EN   8'h18

// status bit positions
`define I2SM_ST_START     3
`define I2SM_ST_RW        2
`define I2SM_ST_RXF       1
`define I2SM_ST_TXF       0

// interrupt event bits
`define I2SM_EV_START     0
`define I2SM_EV_STOP      1
`define I2SM_EV_MATCH     2
`define I2SM_EV_RXB       3
`define I2SM_EV_TXD       4
`define I2SM_EV_W         5

// widths and reset values
`define I2SM_MASK_W       10
`define I2SM_OWN_W        7
`define I2SM_OWN_RST      7'h2A
`define I2SM_LAST_BIT     4'h7
`define I2SM_BYTE_BITS    4'h8
`define I2SM_RESP_OK      2'h0
`define I2SM_RESP_ERR     2'h2

`endif

// ### verilog/i2sm_pkg.sv
// types of the i2c status and address-mask block
// assumes the constants header is on the include path
`default_nettype none
`include "i2sm_consts.svh"

package i2sm_pkg;

    typedef enum logic [2:0] {
        I2SM_IDLE,
        I2SM_ADDR,
        I2SM_ACK,
        I2SM_RX,
        I2SM_TX,
        I2SM_TACK,
        I2SM_TLOAD
    } i2sm_state_t;

    typedef struct packed {
        i2sm_state_t                 st;
        logic [7:0]                  sh;
        logic [3:0]                  bitcnt;
        logic                        ack_on;
        logic                        ack_tx;
        logic                        start_f;
        logic                        rw_f;
        logic                        rxf;
        logic                        txf;
        logic [7:0]                  rx_hold;
        logic [7:0]                  tx_hold;
        logic [`I2SM_MASK_W-1:0]     amask;
        logic [`I2SM_OWN_W-1:0]      own;
        logic [`I2SM_EV_W-1:0]       ien;
        logic [`I2SM_EV_W-1:0]       ist;
        logic                        aw_have;
        logic [7:0]                  awaddr;
        logic                        w_have;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        awready;
        logic                        wready;
        logic                        arready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [1:0]                  rresp;
        logic [31:0]                 rdata;
        logic                        sda_oe;
        logic                        irq;
    } i2sm_regs_t;

endpackage

`default_nettype wire

// ### verilog/i2sm_sync.sv
// two-flop synchroniser for the bus pins
// assumes asynchronous inputs, aclk domain outputs
`default_nettype none
`timescale 1ns/1ps

module i2sm_sync
    import i2sm_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // pins in, synchronised out
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_sync
);

    logic [1:0] stage1_reg;
    logic [1:0] stage2_reg;

    // idle bus is high, so reset to high
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1_reg <= 2'h3;
            stage2_reg <= 2'h3;
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign pin_sync = stage2_reg;

endmodule // i2sm_sync

`default_nettype wire

// ### verilog/i2sm_cond.sv
// bus condition detector: clock edges, start and stop
// assumes synchronised clock and data inputs
`default_nettype none
`timescale 1ns/1ps

module i2sm_cond
    import i2sm_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // synchronised bus lines
    input  wire logic scl,
    input  wire logic sda,
    // one-cycle events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    logic scl_d_reg;
    logic sda_d_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
        end
    end

    // data may only move with clock high for start or stop
    assign scl_rise  = scl & ~scl_d_reg;
    assign scl_fall  = ~scl & scl_d_reg;
    assign start_det = scl & scl_d_reg & sda_d_reg & ~sda;
    assign stop_det  = scl & scl_d_reg & ~sda_d_reg & sda;

endmodule // i2sm_cond

`default_nettype wire

// ### verilog/i2sm_top.sv
// i2c slave with status flags and address mask, axi4-lite registers
// assumes open-drain pads outside; pins sampled on aclk
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
`timescale 1ns/1ps
`include "i2sm_consts.svh"

module i2sm_top
    import i2sm_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // i2c bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // interrupt
    output logic             irq
);

    i2sm_regs_t r_reg;
    i2sm_regs_t r_next;

    logic [1:0] pins_sync;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    // ------------------------------------------------------------
    // pin conditioning
    // ------------------------------------------------------------
    i2sm_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_in   ({scl_i, sda_i}),
        .pin_sync (pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    i2sm_cond u_cond (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .scl       (scl_s),
        .sda       (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte-lane merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // true when the address names an implemented register
    function automatic logic mapped(input logic [7:0] a);
        return (a == `I2SM_OFS_STATUS) || (a == `I2SM_OFS_MASK) ||
               (a == `I2SM_OFS_OWN)    || (a == `I2SM_OFS_RX)   ||
               (a == `I2SM_OFS_TX)     || (a == `I2SM_OFS_IRQ_ST) ||
               (a == `I2SM_OFS_IRQ_EN);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [`I2SM_EV_W-1:0] ev;
        logic [31:0]           wv;
        logic [7:0]            shifted;
        logic                  do_wr;
        logic                  do_rd;
        logic                  rx_load;
        logic                  tx_done;
        logic                  rx_read;
        logic                  tx_write;
        ev       = '0;
        wv       = '0;
        shifted  = {r_reg.sh[6:0], sda_s};
        do_wr    = 1'b0;
        do_rd    = 1'b0;
        rx_load  = 1'b0;
        tx_done  = 1'b0;
        rx_read  = 1'b0;
        tx_write = 1'b0;
        r_next   = r_reg;

        // ---- bus engine ----
        unique case (r_reg.st)
            I2SM_IDLE:
            begin
                r_next.sda_oe = 1'b0;
            end
            I2SM_ADDR:
            begin
                if (scl_rise)
                begin
                    r_next.sh     = shifted;
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    if (r_reg.bitcnt == `I2SM_LAST_BIT)
                    begin
                        // masked positions never block a match
                        if (((shifted[7:1] ^ r_reg.own) &
                             ~r_reg.amask[`I2SM_OWN_W-1:0]) == '0)
                        begin
                            r_next.rw_f   = shifted[0];
                            r_next.ack_tx = shifted[0];
                            r_next.ack_on = 1'b0;
                            r_next.st     = I2SM_ACK;
                            ev[`I2SM_EV_MATCH] = 1'b1;
                        end
                        else
                        begin
                            r_next.st = I2SM_IDLE;
                        end
                    end
                end
            end
            I2SM_ACK:
            begin
                if (scl_fall)
                begin
                    if (!r_reg.ack_on)
                    begin
                        r_next.ack_on = 1'b1;
                        r_next.sda_oe = 1'b1;
                    end
                    else
                    begin
                        r_next.ack_on = 1'b0;
                        r_next.bitcnt = '0;
                        if (r_reg.ack_tx)
                        begin
                            r_next.sh     = r_reg.tx_hold;
                            r_next.sda_oe = ~r_reg.tx_hold[7];
                            r_next.st     = I2SM_TX;
                        end
                        else
                        begin
                            r_next.sda_oe = 1'b0;
                            r_next.st     = I2SM_RX;
                        end
                    end
                end
            end
            I2SM_RX:
            begin
                if (scl_rise)
                begin
                    r_next.sh     = shifted;
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    if (r_reg.bitcnt == `I2SM_LAST_BIT)
                    begin
                        // a full holding register is overwritten
                        r_next.rx_hold = shifted;
                        rx_load        = 1'b1;
                        r_next.ack_tx  = 1'b0;
                        r_next.ack_on  = 1'b0;
                        r_next.st      = I2SM_ACK;
                    end
                end
            end
            I2SM_TX:
            begin
                if (scl_rise)
                begin
                    r_next.bitcnt = r_reg.bitcnt + 4'h1;
                end
                else if (scl_fall)
                begin
                    if (r_reg.bitcnt == `I2SM_BYTE_BITS)
                    begin
                        r_next.sda_oe = 1'b0;
                        tx_done       = 1'b1;
                        r_next.st     = I2SM_TACK;
                    end
                    else
                    begin
                        r_next.sh     = {r_reg.sh[6:0], 1'b0};
                        r_next.sda_oe = ~r_reg.sh[6];
                    end
                end
            end
            I2SM_TACK:
            begin
                // nack from master ends the read; wait for stop
                if (scl_rise)
                begin
                    r_next.st = sda_s ? I2SM_IDLE : I2SM_TLOAD;
                end
            end
            I2SM_TLOAD:
            begin
                if (scl_fall)
                begin
                    r_next.sh     = r_reg.tx_hold;
                    r_next.sda_oe = ~r_reg.tx_hold[7];
                    r_next.bitcnt = '0;
                    r_next.st     = I2SM_TX;
                end
            end
        endcase

        // bus conditions override the byte engine
        if (start_det)
        begin
            r_next.start_f = 1'b1;
            r_next.st      = I2SM_ADDR;
            r_next.bitcnt  = '0;
            r_next.sda_oe  = 1'b0;
            ev[`I2SM_EV_START] = 1'b1;
        end
        else if (stop_det)
        begin
            r_next.start_f = 1'b0;
            r_next.st      = I2SM_IDLE;
            r_next.sda_oe  = 1'b0;
            ev[`I2SM_EV_STOP] = 1'b1;
        end

        // ---- axi write channel ----
        if (s_axi_awvalid && r_reg.awready)
        begin
            r_next.aw_have = 1'b1;
            r_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_reg.wready)
        begin
            r_next.w_have = 1'b1;
            r_next.wdata  = s_axi_wdata;
            r_next.wstrb  = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid)
        begin
            do_wr          = 1'b1;
            r_next.aw_have = 1'b0;
            r_next.w_have  = 1'b0;
            r_next.bvalid  = 1'b1;
            r_next.bresp   = mapped(r_reg.awaddr) ? `I2SM_RESP_OK
                                                  : `I2SM_RESP_ERR;
        end
        if (do_wr)
        begin
            // status writes fall through: the status offset has no case arm
            unique case (r_reg.awaddr)
                `I2SM_OFS_MASK:
                begin
                    wv = merge({22'h0, r_reg.amask}, r_reg.wdata, r_reg.wstrb);
                    r_next.amask = wv[`I2SM_MASK_W-1:0];
                end
                `I2SM_OFS_OWN:
                begin
                    wv = merge({25'h0, r_reg.own}, r_reg.wdata, r_reg.wstrb);
                    r_next.own = wv[`I2SM_OWN_W-1:0];
                end
                `I2SM_OFS_TX:
                begin
                    if (r_reg.wstrb[0])
                    begin
                        r_next.tx_hold = r_reg.wdata[7:0];
                        tx_write       = 1'b1;
                    end
                end
                `I2SM_OFS_IRQ_ST:
                begin
                    if (r_reg.wstrb[0])
                    begin
                        r_next.ist = r_reg.ist & ~r_reg.wdata[`I2SM_EV_W-1:0];
                    end
                end
                `I2SM_OFS_IRQ_EN:
                begin
                    if (r_reg.wstrb[0])
                    begin
                        r_next.ien = r_reg.wdata[`I2SM_EV_W-1:0];
                    end
                end
                default:
                begin
                end
            endcase
        end

        // ---- axi read channel ----
        if (s_axi_rvalid && s_axi_rready)
        begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r_reg.arready)
        begin
            do_rd         = 1'b1;
            r_next.rvalid = 1'b1;
            r_next.rresp  = mapped(s_axi_araddr) ? `I2SM_RESP_OK
                                                 : `I2SM_RESP_ERR;
            r_next.rdata  = '0;
            unique case (s_axi_araddr)
                `I2SM_OFS_STATUS:
                begin
                    r_next.rdata[`I2SM_ST_START] = r_reg.start_f;
                    r_next.rdata[`I2SM_ST_RW]    = r_reg.rw_f;
                    r_next.rdata[`I2SM_ST_RXF]   = r_reg.rxf;
                    r_next.rdata[`I2SM_ST_TXF]   = r_reg.txf;
                end
                `I2SM_OFS_MASK:
                begin
                    r_next.rdata[`I2SM_MASK_W-1:0] = r_reg.amask;
                end
                `I2SM_OFS_OWN:
                begin
                    r_next.rdata[`I2SM_OWN_W-1:0] = r_reg.own;
                end
                `I2SM_OFS_RX:
                begin
                    r_next.rdata[7:0] = r_reg.rx_hold;
                    rx_read           = 1'b1;
                end
                `I2SM_OFS_TX:
                begin
                    r_next.rdata[7:0] = r_reg.tx_hold;
                end
                `I2SM_OFS_IRQ_ST:
                begin
                    r_next.rdata[`I2SM_EV_W-1:0] = r_reg.ist;
                end
                `I2SM_OFS_IRQ_EN:
                begin
                    r_next.rdata[`I2SM_EV_W-1:0] = r_reg.ien;
                end
                default:
                begin
                end
            endcase
        end

        // ---- holding flags: a set in the same cycle beats a clear ----
        if (rx_load)
        begin
            r_next.rxf = 1'b1;
            ev[`I2SM_EV_RXB] = 1'b1;
        end
        else if (rx_read)
        begin
            r_next.rxf = 1'b0;
        end
        if (tx_write)
        begin
            r_next.txf = 1'b1;
        end
        else if (tx_done)
        begin
            r_next.txf = 1'b0;
            ev[`I2SM_EV_TXD] = 1'b1;
        end

        // ---- interrupts: events set after the clear, so they win ----
        r_next.ist = r_next.ist | ev;
        r_next.irq = |(r_next.ist & r_next.ien);

        // ready flags registered so outputs stay flop-driven
        r_next.awready = !r_next.aw_have && !r_next.bvalid;
        r_next.wready  = !r_next.w_have && !r_next.bvalid;
        r_next.arready = !r_next.rvalid;
        if (do_rd)
        begin
            r_next.arready = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_reg     <= '0;
            r_reg.st  <= I2SM_IDLE;
            r_reg.own <= `I2SM_OWN_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready  = r_reg.wready;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rdata   = r_reg.rdata;
    assign s_axi_rresp   = r_reg.rresp;
    // open drain: only ever pulls low
    assign sda_o         = 1'b0;
    assign sda_oe        = r_reg.sda_oe;
    assign irq           = r_reg.irq;

endmodule // i2sm_top

`default_nettype wire

// ### testbench/i2sm_top_sva.sv
// port checks for the i2c status and mask block
// assumes binding onto i2sm_top, one clock domain
`timescale 1ns/1ps
`default_nettype none

module i2sm_top_sva (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // interrupt
    input wire logic        irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic rd_take = s_axi_arvalid && s_axi_arready;

    AST_MASK_HI: assert property (rd_take && s_axi_araddr == 8'h04
        |=> s_axi_rdata[31:10] == 22'h0) else $error("mask high bits set");
    AST_STAT_HI: assert property (rd_take && s_axi_araddr == 8'h00
        |=> s_axi_rdata[31:4] == 28'h0) else $error("status high bits set");
    AST_UNMAP: assert property (rd_take && s_axi_araddr > 8'h18
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
    AST_RD_LAT: assert property (rd_take |=> s_axi_rvalid) else $error("read late");
    AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
    AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during response");
    AST_WR_BACK: assert property ($fell(s_axi_bvalid) |=> s_axi_awready && s_axi_wready)
        else $error("write ready not back");
    AST_IRQ_RST: assert property ($rose(aresetn) |-> !irq) else $error("irq after reset");
endmodule // i2sm_top_sva

bind i2sm_top i2sm_top_sva i2sm_top_sva_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq)
);

`default_nettype wire

// ### testbench/i2sm_master_model.sv
// behavioural i2c master: push-pull clock, open-drain data
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
`default_nettype none

module i2sm_master_model (
    // bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // clock stands high between frames
    task automatic begin_frame();
        sda_low <= 1'b1;
        #120 scl <= 1'b0;
    endtask
    task automatic end_frame();
        #120 sda_low <= 1'b1;
        #80 scl <= 1'b1;
        #120 sda_low <= 1'b0;
        #200;
    endtask
    // low 200 ns so the slave's late data change settles before the rise
    task automatic bit_io(input logic o, output logic i);
        #120 sda_low <= !o;
        #80 scl <= 1'b1;
        #60 i = sda;
        #60 scl <= 1'b0;
    endtask
    task automatic send(input logic [7:0] b, output logic acked);
        logic x;
        for (int k = 7; k >= 0; k--) bit_io(b[k], x);
        bit_io(1'b1, x);
        acked = !x;
    endtask
    task automatic recv(input logic ack, output logic [7:0] b);
        logic x;
        for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
        bit_io(!ack, x);
    endtask
endmodule // i2sm_master_model

`default_nettype wire

// ### testbench/i2sm_top_tb.sv
// self-checking bench: register bus and i2c frames through a master model
// assumes design files and master model compiled first
`timescale 1ns/1ps
`default_nettype none

module i2sm_top_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, got;
    logic [1:0]  rresp, bresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, sda_oe, irq, scl, sda_low, ack;
    logic [7:0]  rxb;
    wire logic   sda_w = !(sda_low || sda_oe);
    int          errors = 0;
    int          compares = 0;

    always #20 aclk = !aclk;

    i2sm_top i2sm_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .scl_i(scl), .sda_i(sda_w), .sda_o(),
        .sda_oe(sda_oe), .irq(irq)
    );
    i2sm_master_model i2sm_master_model_inst (.scl(scl), .sda_low(sda_low), .sda(sda_w));

    task automatic close_out();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(got, exp);
    endtask

    initial
    begin
        #200000;
        errors++;
        close_out();
    end

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h08, 32'h2A);
        axw(8'h00, 32'hF);
        rd_chk(8'h00, 32'h0);
        axw(8'h04, 32'hFFFFFFFF);
        rd_chk(8'h04, 32'h3FF);
        axr(8'h1C);
        chk(32'(resp), 32'h2);
        axw(8'h1C, 32'h0);
        chk(32'(resp), 32'h2);
        axw(8'h04, 32'h0);
        axw(8'h18, 32'h2);
        // ---------------------------------
        // write frame to own address
        // ---------------------------------
        i2sm_master_model_inst.begin_frame();
        rd_chk(8'h00, 32'h8);
        i2sm_master_model_inst.send(8'h54, ack);
        chk(32'(ack), 32'h1);
        rd_chk(8'h00, 32'h8);
        i2sm_master_model_inst.send(8'hA5, ack);
        rd_chk(8'h00, 32'hA);
        rd_chk(8'h0C, 32'hA5);
        rd_chk(8'h00, 32'h8);
        i2sm_master_model_inst.end_frame();
        rd_chk(8'h00, 32'h0);
        chk(32'(irq), 32'h1);
        axw(8'h14, 32'h2);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        axw(8'h18, 32'h0);
        // ---------------------------------
        // mask bit 0, then read frame
        // ---------------------------------
        i2sm_master_model_inst.begin_frame();
        i2sm_master_model_inst.send(8'h56, ack);
        chk(32'(ack), 32'h0);
        i2sm_master_model_inst.end_frame();
        axw(8'h04, 32'h1);
        axw(8'h10, 32'h3C);
        rd_chk(8'h00, 32'h1);
        i2sm_master_model_inst.begin_frame();
        i2sm_master_model_inst.send(8'h57, ack);
        chk(32'(ack), 32'h1);
        rd_chk(8'h00, 32'hD);
        i2sm_master_model_inst.recv(1'b0, rxb);
        chk(32'(rxb), 32'h3C);
        rd_chk(8'h00, 32'hC);
        i2sm_master_model_inst.end_frame();
        rd_chk(8'h00, 32'h4);
        chk(32'(irq), 32'h0);
        axr(8'h14);
        chk(32'(got[1]), 32'h1);
        close_out();
    end
endmodule // i2sm_top_tb

`default_nettype wire
